// *** hw/ssv_safe_state_supervisor.sv ***
// Device state machine: SAFE entry, hold, exit, error count, resets.
// Assumes synchronous inputs; the controller clears the flags.
`timescale 1ns/1ps
module ssv_safe_state_supervisor
  import ssv_pkg::*;
#(
  parameter int SAFE_UNIT    = SAFE_UNIT_CYC,
  parameter int SAFE_LONG    = SAFE_LONG_CYC,
  parameter int DIAG_TIMEOUT = DIAG_TIMEOUT_CYC,
  parameter int DIG_FILTER   = DIG_FILTER_CYC,
  parameter int RESET_EXT    = RESET_EXT_CYC
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             clock_loss_detect,
  input  wire logic             monitor_supply_error,
  input  wire logic             digital_supply_undervolt,
  input  wire logic             digital_supply_overvolt,
  input  wire logic             battery_undervolt,
  input  wire logic             io_reg_overtemp,
  input  wire logic             io_reg_overtemp_unmask,
  input  wire logic             analog_supply_undervolt,
  input  wire logic             monitor_trim_error,
  input  wire logic             bandgap_error_one,
  input  wire logic             bandgap_error_two,
  input  wire logic             charge_pump_low_overvolt,
  input  wire logic             charge_pump_high_overvolt,
  input  wire logic             ignition_input,
  input  wire logic             bus_wake_input,
  input  wire logic             mcu_error_signal_monitor_enable,
  input  wire logic             mcu_error_signal_monitor_fault,
  input  wire logic             reset_readback_mismatch,
  input  wire logic             reset_monitor_disable,
  input  wire logic             bit_a,
  input  wire logic             bit_b,
  input  wire logic             watchdog_fail_flag,
  input  wire logic             error_pin_fail_clear,
  input  wire logic             reset_readback_error_clear,
  input  wire logic             cfg_crc_error_flag,
  input  wire logic             cfg_crc_enable,
  input  wire logic             nvm_crc_error_flag,
  input  wire logic             analog_self_test_error,
  input  wire logic             logic_self_test_error,
  input  wire logic             safe_no_timeout_bit,
  input  wire logic [3:0]       safe_lock_threshold,
  input  wire logic [2:0]       safe_timeout_setting,
  input  wire logic [3:0]       power_down_threshold,
  input  wire logic             power_down_threshold_use,
  input  wire logic             five_volt_reg_enable,
  input  wire logic             sensor_supply_enable,
  input  wire logic             auto_self_test_disable,
  input  wire logic             driver_enable_request,
  output ssv_state_t            state,
  output logic                  mcu_reset_output,
  output logic                  driver_enable_output,
  output logic                  main_reg_on,
  output logic                  five_volt_on,
  output logic                  sensor_supply_on,
  output logic [ERR_W-1:0]      device_error_counter,
  output logic                  error_pin_fail_flag,
  output logic                  reset_readback_error_flag,
  output logic                  self_test_start,
  output logic                  post_test_reinit,
  output logic                  power_on_reset_event
);

  // Safe time-out length for a given three-bit setting
  function automatic logic [TMR_W-1:0] safe_limit(input logic [2:0] setting);
    safe_limit = TMR_W'({setting, 1'b1}) * TMR_W'(SAFE_UNIT);
  endfunction

  // Saturating increment of the error count
  function automatic logic [ERR_W-1:0] err_inc(input logic [ERR_W-1:0] cnt);
    err_inc = (cnt == ERR_CNT_MAX) ? cnt : ERR_W'(cnt + 1'b1);
  endfunction

  ssv_state_t       next_state;
  logic             next_mcu_reset_output;
  logic             next_driver_enable_output;
  logic             next_main_reg_on;
  logic             next_five_volt_on;
  logic             next_sensor_supply_on;
  logic [ERR_W-1:0] next_device_error_counter;
  logic             next_error_pin_fail_flag;
  logic             next_reset_readback_error_flag;
  logic             next_self_test_start;
  logic             next_post_test_reinit;
  logic             next_power_on_reset_event;
  logic             from_standby;
  logic             next_from_standby;

  logic [TMR_W-1:0] state_time;
  logic [TMR_W-1:0] fault_time;
  logic             state_change;
  logic             analog_por;
  logic             digital_fault;
  logic             digital_por;
  logic             wake;
  logic [ERR_W:0]   lock_limit;
  logic             over_lock;
  logic             pwd_hit;
  logic             req_standby;
  logic             req_reset;
  logic             req_safe;
  logic             req_other;
  ssv_state_t       other_target;
  logic             esm_trip;
  logic             readback_trip;
  logic             cfg_crc_trip;
  logic             diag_timeout;
  logic             exit_blocked;

  // Analog causes act at once; digital ones are filtered
  assign analog_por = clock_loss_detect | monitor_supply_error
                    | digital_supply_undervolt | digital_supply_overvolt;
  assign digital_fault = battery_undervolt | (io_reg_overtemp & io_reg_overtemp_unmask)
                       | analog_supply_undervolt | monitor_trim_error
                       | bandgap_error_one | bandgap_error_two
                       | charge_pump_low_overvolt | charge_pump_high_overvolt;
  // One pulse per fault episode; glitches never reach the limit
  assign digital_por = digital_fault
                     && (fault_time == TMR_W'(DIG_FILTER - 1));
  assign wake = ignition_input | bus_wake_input;

  ssv_timer #(
    .W (TMR_W)
  ) u_fault_filter (
    .clock (clock),
    .rst_b (rst_b),
    .clear (!digital_fault),
    .run   (digital_fault),
    .count (fault_time)
  );

  // State timer restarts on every state change
  assign state_change = (next_state != state);

  ssv_timer #(
    .W (TMR_W)
  ) u_state_timer (
    .clock (clock),
    .rst_b (rst_b),
    .clear (state_change),
    .run   (1'b1),
    .count (state_time)
  );

  assign lock_limit = {1'b0, safe_lock_threshold} + 5'h01;
  assign over_lock  = ({1'b0, device_error_counter} >= lock_limit);
  assign pwd_hit    = power_down_threshold_use
                    && (device_error_counter >= power_down_threshold);

  assign esm_trip      = mcu_error_signal_monitor_enable & mcu_error_signal_monitor_fault;
  assign readback_trip = reset_readback_mismatch & !reset_monitor_disable;
  assign cfg_crc_trip  = cfg_crc_error_flag & !cfg_crc_enable;
  // Mask bit holds DIAGNOSTIC; timer keeps running
  assign diag_timeout  = (state_time >= TMR_W'(DIAG_TIMEOUT)) && !bit_a && !bit_b;
  assign exit_blocked  = watchdog_fail_flag | error_pin_fail_flag;

  // Transition requests per priority class
  always_comb begin
    req_standby  = 1'b0;
    req_reset    = 1'b0;
    req_safe     = 1'b0;
    req_other    = 1'b0;
    other_target = state;
    case (state)
      ST_STANDBY: begin
        req_reset = wake;
      end
      ST_RESET: begin
        if (state_time >= TMR_W'(RESET_EXT)) begin
          req_other    = 1'b1;
          other_target = ST_DIAG;
        end
      end
      ST_DIAG: begin
        req_safe = cfg_crc_trip
                 | nvm_crc_error_flag | analog_self_test_error
                 | logic_self_test_error
                 | diag_timeout
                 | (bit_b & exit_blocked);
        if (bit_b && !exit_blocked) begin
          req_other    = 1'b1;
          other_target = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        req_safe = esm_trip
                 | readback_trip
                 | cfg_crc_trip;
      end
      ST_SAFE: begin
        req_standby = pwd_hit;
        if (!over_lock) begin
          req_reset = (state_time >= safe_limit(safe_timeout_setting));
        end else if (!safe_no_timeout_bit) begin
          req_reset = (state_time >= TMR_W'(SAFE_LONG));
        end
        // Locked with no time-out: no reset request; only power-down or a power-on reset leaves SAFE
      end
      default: begin
        req_reset = 1'b1;
      end
    endcase
  end

  // Next state and registered outputs
  always_comb begin
    next_state                     = state;
    next_from_standby              = from_standby;
    next_device_error_counter      = device_error_counter;
    next_error_pin_fail_flag       = error_pin_fail_flag;
    next_reset_readback_error_flag = reset_readback_error_flag;
    next_self_test_start           = 1'b0;
    next_post_test_reinit          = 1'b0;
    next_power_on_reset_event      = 1'b0;

    // Priority order of simultaneous requests
    if (req_standby) begin
      next_state = ST_STANDBY;
    end else if (req_reset) begin
      next_state = ST_RESET;
    end else if (req_safe) begin
      next_state = ST_SAFE;
    end else if (req_other) begin
      next_state = other_target;
    end

    if (state == ST_STANDBY && next_state == ST_RESET) begin
      next_from_standby = 1'b1;
    end

    // Self-test on leaving RESET; the power-up run cannot be disabled
    if (state == ST_RESET && next_state == ST_DIAG) begin
      next_self_test_start  = 1'b1;
      next_post_test_reinit = !auto_self_test_disable || from_standby;
      next_from_standby     = 1'b0;
    end

    if (next_state == ST_SAFE && state != ST_SAFE) begin
      next_device_error_counter = err_inc(device_error_counter);
    end

    // Set wins over a clear in the same cycle
    if (error_pin_fail_clear) begin
      next_error_pin_fail_flag = 1'b0;
    end
    if ((state == ST_ACTIVE && esm_trip) || (state == ST_DIAG && diag_timeout)) begin
      next_error_pin_fail_flag = 1'b1;
    end
    if (reset_readback_error_clear) begin
      next_reset_readback_error_flag = 1'b0;
    end
    if (state == ST_ACTIVE && readback_trip) begin
      next_reset_readback_error_flag = 1'b1;
    end

    // Power-on resets override all and reload every register
    if (analog_por || digital_por) begin
      next_state                     = (digital_por && !analog_por && wake)
                                     ? ST_RESET : ST_STANDBY;
      next_from_standby              = 1'b1;
      next_device_error_counter      = ERR_CNT_RESET;
      next_error_pin_fail_flag       = 1'b0;
      next_reset_readback_error_flag = 1'b0;
      next_self_test_start           = 1'b0;
      next_post_test_reinit          = 1'b0;
      next_power_on_reset_event      = 1'b1;
    end
  end

  // Pin levels follow the state being entered
  always_comb begin
    next_main_reg_on          = (next_state != ST_STANDBY);
    next_mcu_reset_output     = 1'b0;
    next_driver_enable_output = 1'b0;
    case (next_state)
      ST_DIAG, ST_ACTIVE: begin
        next_mcu_reset_output     = 1'b1;
        next_driver_enable_output = driver_enable_request;
      end
      ST_SAFE: begin
        next_mcu_reset_output     = 1'b1;
        next_driver_enable_output = 1'b0;
      end
      default: begin
      end
    endcase
    // Switchable rails obey their enables
    next_five_volt_on     = next_main_reg_on && five_volt_reg_enable;
    next_sensor_supply_on = next_main_reg_on && sensor_supply_enable;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state                     <= ST_STANDBY;
      from_standby              <= 1'b1;
      mcu_reset_output          <= 1'b0;
      driver_enable_output      <= 1'b0;
      main_reg_on               <= 1'b0;
      five_volt_on              <= 1'b0;
      sensor_supply_on          <= 1'b0;
      device_error_counter      <= ERR_CNT_RESET;
      error_pin_fail_flag       <= 1'b0;
      reset_readback_error_flag <= 1'b0;
      self_test_start           <= 1'b0;
      post_test_reinit          <= 1'b0;
      power_on_reset_event      <= 1'b0;
    end else begin
      state                     <= next_state;
      from_standby              <= next_from_standby;
      mcu_reset_output          <= next_mcu_reset_output;
      driver_enable_output      <= next_driver_enable_output;
      main_reg_on               <= next_main_reg_on;
      five_volt_on              <= next_five_volt_on;
      sensor_supply_on          <= next_sensor_supply_on;
      device_error_counter      <= next_device_error_counter;
      error_pin_fail_flag       <= next_error_pin_fail_flag;
      reset_readback_error_flag <= next_reset_readback_error_flag;
      self_test_start           <= next_self_test_start;
      post_test_reinit          <= next_post_test_reinit;
      power_on_reset_event      <= next_power_on_reset_event;
    end
  end

endmodule

// *** hw/ssv_pkg.sv ***
// Constants, state type and timing counts for the supervisor.
// Assumes one 25 MHz clock and an async active-low reset.
// Function
// - ACTIVE: enabled monitor fault enters SAFE, sets error-pin-fail.
// - ACTIVE: unmasked reset readback mismatch sets flag, enters SAFE.
// - DIAGNOSTIC: time-out before mask or exit bit enters SAFE.
// - Config CRC error with CRC enable low enters SAFE.
// - DIAGNOSTIC: memory CRC or self-test error enters SAFE.
// - Exit bit with watchdog or error-pin flag set enters SAFE.
// - Each SAFE entry adds one to the error counter, up to 15.
// - SAFE: controller reset output high, driver enable low.
// - SAFE: main rails on; 5 V and sensor rails follow enables.
// - Below lock limit, SAFE time-out is (setting*2+1)*22 ms.
// - No-time-out set and count at lock limit: stay in SAFE.
// - No-time-out clear and count at lock limit: RESET after 680 ms.
// - Count at used power-down threshold: Safe_timeout_setting STANDBY first.
// - Priority: STANDBY, then RESET, then SAFE, then others.
// - Analog reset causes reinitialise every register.
// - Filtered digital reset causes reinitialise; under 6 ms may be ignored.
// - After digital reset, held wake input enters RESET.
// - Post-test reinit on RESET to DIAGNOSTIC unless auto test disabled; always after STANDBY or power-on reset.
// - SAFE time-out below lock limit moves Safe_timeout_setting RESET.
package ssv_pkg;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_RESET,
    ST_DIAG,
    ST_ACTIVE,
    ST_SAFE
  } ssv_state_t;

  localparam int CLK_KHZ         = 25000;
  localparam int TMR_W           = 25;
  localparam int ERR_W           = 4;
  localparam int SAFE_UNIT_MS    = 22;
  localparam int SAFE_LONG_MS    = 680;
  localparam int DIAG_TIMEOUT_MS = 512;
  localparam int DIG_FILTER_MS   = 6;
  localparam int RESET_EXT_US    = 100;

  localparam int SAFE_UNIT_CYC    = SAFE_UNIT_MS * CLK_KHZ;
  localparam int SAFE_LONG_CYC    = SAFE_LONG_MS * CLK_KHZ;
  localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_MS * CLK_KHZ;
  localparam int DIG_FILTER_CYC   = DIG_FILTER_MS * CLK_KHZ;
  localparam int RESET_EXT_CYC    = (RESET_EXT_US * CLK_KHZ + 999) / 1000;

  localparam logic [ERR_W-1:0] ERR_CNT_RESET = 4'h0;
  localparam logic [ERR_W-1:0] ERR_CNT_MAX   = 4'hF;

endpackage

// *** hw/ssv_timer.sv ***
// Saturating up-counter: state timer and fault filter.
// Assumes clear and run are synchronous to clock.
`timescale 1ns/1ps
module ssv_timer #(
  parameter int W = 25
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         clear,
  input  wire logic         run,
  output logic     [W-1:0]  count
);

  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (run && (count != {W{1'b1}})) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// *** verif/ssv_checker.sv ***
// Port assertions for the safe-state supervisor; bound below the module.
// Timing parameters come through the bind.
`timescale 1ns/1ps
module ssv_checker
  import ssv_pkg::*;
#(
  parameter int SAFE_UNIT    = 10,
  parameter int SAFE_LONG    = 50,
  parameter int DIAG_TIMEOUT = 40
) (
  input wire logic       clock, rst_b, clock_loss_detect, monitor_supply_error,
  input wire logic       digital_supply_undervolt, digital_supply_overvolt,
  input wire logic       mcu_error_signal_monitor_enable, mcu_error_signal_monitor_fault,
  input wire logic       reset_readback_mismatch, reset_monitor_disable, bit_a, bit_b,
  input wire logic       watchdog_fail_flag, safe_no_timeout_bit, power_down_threshold_use,
  input wire logic       auto_self_test_disable, mcu_reset_output, driver_enable_output,
  input wire logic       main_reg_on, error_pin_fail_flag, reset_readback_error_flag,
  input wire logic       post_test_reinit, power_on_reset_event,
  input wire logic [3:0] safe_lock_threshold, power_down_threshold, device_error_counter,
  input wire logic [2:0] safe_timeout_setting,
  input wire ssv_state_t state
);
  ssv_state_t prev;
  int         cnt_q;
  int         cyc;
  int         tmo;
  logic       below;
  logic       pwd;
  logic       safe_short;
  // Dwell is zero in the first cycle of every state
  always_comb begin
    cyc        = (state != prev) ? 0 : cnt_q + 1;
    tmo        = (2 * int'(safe_timeout_setting) + 1) * SAFE_UNIT;
    below      = {1'b0, device_error_counter} < {1'b0, safe_lock_threshold} + 5'h01;
    pwd        = power_down_threshold_use && device_error_counter >= power_down_threshold;
    safe_short = state == ST_SAFE && below && !pwd;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev  <= ST_STANDBY;
      cnt_q <= 0;
    end else begin
      prev  <= state;
      cnt_q <= cyc;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  safe_pins_a: assert property (
    state == ST_SAFE |-> mcu_reset_output && !driver_enable_output && main_reg_on)
    else $error("safe pins wrong");
  esm_entry_a: assert property (
    state == ST_ACTIVE && mcu_error_signal_monitor_enable && mcu_error_signal_monitor_fault
    |=> state == ST_SAFE && error_pin_fail_flag) else $error("monitor fault missed");
  readback_a: assert property (
    state == ST_ACTIVE && reset_readback_mismatch && !reset_monitor_disable
    |=> state == ST_SAFE && reset_readback_error_flag) else $error("readback missed");
  exit_flags_a: assert property (
    state == ST_DIAG && bit_b && (watchdog_fail_flag || error_pin_fail_flag)
    |=> state == ST_SAFE) else $error("exit with flags set");
  count_step_a: assert property (
    $rose(state == ST_SAFE) |-> device_error_counter == ($past(device_error_counter) == 4'hF
    ? 4'hF : $past(device_error_counter) + 4'h1)) else $error("error count step wrong");
  safe_tmo_a: assert property (
    state == ST_SAFE && below && $stable(safe_timeout_setting) |-> cyc <= tmo + 1)
    else $error("safe time-out late");
  safe_exit_a: assert property (
    $past(safe_short) && state == ST_RESET |-> $past(cyc) + 1 >= $past(tmo))
    else $error("safe time-out early");
  safe_lock_a: assert property (
    state == ST_SAFE && !below && !pwd && safe_no_timeout_bit |=> state == ST_SAFE)
    else $error("lock left");
  safe_long_a: assert property (
    state == ST_SAFE && !below && !safe_no_timeout_bit && $stable(safe_no_timeout_bit)
    |-> cyc <= SAFE_LONG + 1) else $error("long time-out late");
  power_down_a: assert property (
    state == ST_SAFE && pwd |=> state == ST_STANDBY) else $error("power-down missed");
  diag_tmo_a: assert property (
    state == ST_DIAG && !bit_a |-> cyc <= DIAG_TIMEOUT + 1) else $error("diag time-out late");
  analog_por_a: assert property (
    clock_loss_detect || monitor_supply_error || digital_supply_undervolt ||
    digital_supply_overvolt |=> state == ST_STANDBY && device_error_counter == 4'h0)
    else $error("analog reset missed");
  post_reinit_a: assert property (
    $rose(state == ST_DIAG) && !auto_self_test_disable |-> post_test_reinit)
    else $error("post-test reinit missing");
  cover property (state == ST_SAFE && !below && safe_no_timeout_bit);
  cover property (state == ST_SAFE && pwd);
  cover property (power_on_reset_event);
endmodule

bind ssv_safe_state_supervisor ssv_checker #(.SAFE_UNIT(SAFE_UNIT), .SAFE_LONG(SAFE_LONG),
  .DIAG_TIMEOUT(DIAG_TIMEOUT)) u_chk (.*);

// *** verif/ssv_mcu_model.sv ***
// Controller model: error output, diagnostic exit and flag clearing.
// Assumes bench commands change at the falling clock edge.
`timescale 1ns/1ps
module ssv_mcu_model (
  input  wire logic clock,
  input  wire logic mcu_reset_output,
  input  wire logic fault_cmd,
  input  wire logic exit_cmd,
  input  wire logic keep_flags,
  output logic      mcu_error_signal_monitor_fault,
  output logic      bit_b,
  output logic      watchdog_fail_flag,
  output logic      error_pin_fail_clear
);
  logic [1:0] phase;
  initial {mcu_error_signal_monitor_fault, bit_b, watchdog_fail_flag, error_pin_fail_clear,
    phase} = '0;
  // Held in reset, the controller drives nothing active
  always @(negedge clock) begin
    mcu_error_signal_monitor_fault <= mcu_reset_output & fault_cmd;
    watchdog_fail_flag <= mcu_reset_output & keep_flags;
    error_pin_fail_clear <= 1'b0;
    bit_b <= 1'b0;
    if (!exit_cmd || !mcu_reset_output) begin
      phase <= 2'h0;
    end else if (phase == 2'h0) begin
      error_pin_fail_clear <= ~keep_flags;
      phase <= 2'h1;
    end else if (phase == 2'h1) begin
      bit_b <= 1'b1;
      phase <= 2'h2;
    end
  end
endmodule

// *** verif/ssv_safe_state_supervisor_tb.sv ***
// Bench: state changes checked against queued notes.
// Assumes the bound checker; timing is shortened.
`timescale 1ns/1ps
module ssv_safe_state_supervisor_tb;
  import ssv_pkg::*;
  localparam int UNIT = 10;
  localparam int LONG = 50;
  localparam int DIAG = 40;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ignition_input, bus_wake_input, reset_readback_mismatch, bit_a, cfg_crc_error_flag;
  logic cfg_crc_enable, power_down_threshold_use, sensor_supply_enable, auto_self_test_disable;
  logic reset_readback_error_clear, fault_cmd, exit_cmd, keep_flags, safe_no_timeout_bit;
  logic mcu_error_signal_monitor_enable, reset_monitor_disable, five_volt_reg_enable;
  logic driver_enable_request, io_reg_overtemp_unmask;
  logic [3:0] safe_lock_threshold, power_down_threshold;
  logic [2:0] safe_timeout_setting;
  logic [7:0] dig = 8'h00;
  logic [3:0] ana = 4'h0;
  logic [2:0] bist = 3'h0;
  wire clock_loss_detect, monitor_supply_error, digital_supply_undervolt;
  wire digital_supply_overvolt, battery_undervolt, io_reg_overtemp, analog_supply_undervolt;
  wire monitor_trim_error, bandgap_error_one, bandgap_error_two, charge_pump_low_overvolt;
  wire charge_pump_high_overvolt, nvm_crc_error_flag, analog_self_test_error;
  wire logic_self_test_error, mcu_error_signal_monitor_fault, bit_b, watchdog_fail_flag;
  wire error_pin_fail_clear;
  ssv_state_t state;
  logic mcu_reset_output, driver_enable_output, main_reg_on, five_volt_on, sensor_supply_on;
  logic error_pin_fail_flag, reset_readback_error_flag, self_test_start, post_test_reinit;
  logic power_on_reset_event;
  logic [ERR_W-1:0] device_error_counter;
  int mismatches = 0;
  int compares = 0;
  int n;
  int tmo;
  logic [31:0] rng = 32'h0000_0027;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  ssv_state_t last = ST_STANDBY;
  assign {clock_loss_detect, monitor_supply_error, digital_supply_undervolt,
    digital_supply_overvolt} = ana;
  assign {battery_undervolt, io_reg_overtemp, analog_supply_undervolt, monitor_trim_error,
    bandgap_error_one, bandgap_error_two, charge_pump_low_overvolt,
    charge_pump_high_overvolt} = dig;
  assign {nvm_crc_error_flag, analog_self_test_error, logic_self_test_error} = bist;
  ssv_safe_state_supervisor #(.SAFE_UNIT(UNIT), .SAFE_LONG(LONG), .DIAG_TIMEOUT(DIAG),
    .DIG_FILTER(5), .RESET_EXT(4)) dut (.*);
  ssv_mcu_model mcu (.*);
  always #20 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bit 4 of c: state only
  task automatic expect_st(input ssv_state_t s, input logic [4:0] c);
    exp_q.push_back({c[4], s, c[3:0]});
  endtask
  task automatic wait_st(input ssv_state_t s, output int k);
    k = 0;
    while (state !== s) begin
      @(negedge clock);
      k++;
      if (k > 400) begin
        mismatches++;
        conclude();
      end
    end
  endtask
  task automatic leave_diag(input logic keep, input logic [3:0] c);
    keep_flags = keep;
    exit_cmd = 1'b1;
    expect_st(keep ? ST_SAFE : ST_ACTIVE, {1'b0, c});
    wait_st(keep ? ST_SAFE : ST_ACTIVE, n);
    exit_cmd = 1'b0;
    keep_flags = 1'b0;
  endtask
  task automatic safe_out(input int t, input logic [3:0] c);
    expect_st(ST_RESET, {1'b0, c});
    expect_st(ST_DIAG, {1'b0, c});
    wait_st(ST_RESET, n);
    check(8'(n >= t - 1 && n <= t + 1), 8'h01);
    wait_st(ST_DIAG, n);
  endtask
  always @(posedge clock) begin
    #1;
    if (state !== last) begin
      if (exp_q.size() == 0) begin
        check({1'b0, state, device_error_counter}, 8'hFF);
      end else begin
        e = exp_q.pop_front();
        if (e[7]) check({1'b0, state, 4'h0}, {1'b0, e[6:4], 4'h0});
        else check({1'b0, state, device_error_counter}, e);
      end
      last = state;
    end
  end
  initial begin
    {ignition_input, bus_wake_input, reset_readback_mismatch, bit_a, cfg_crc_error_flag,
      cfg_crc_enable, power_down_threshold_use, sensor_supply_enable, auto_self_test_disable,
      reset_readback_error_clear, fault_cmd, exit_cmd, keep_flags} = '0;
    {mcu_error_signal_monitor_enable, reset_monitor_disable, safe_no_timeout_bit,
      five_volt_reg_enable, driver_enable_request, io_reg_overtemp_unmask} = '1;
    safe_lock_threshold = 4'h2;
    power_down_threshold = 4'h6;
    rng = xs(rng);
    safe_timeout_setting = rng[2:0];
    tmo = (2 * int'(rng[2:0]) + 1) * UNIT;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    ignition_input = 1'b1;
    expect_st(ST_RESET, 5'h00);
    expect_st(ST_DIAG, 5'h00);
    wait_st(ST_DIAG, n);
    ignition_input = 1'b0;
    leave_diag(1'b0, 4'h0);
    // Monitor off by default: no change
    reset_readback_mismatch = 1'b1;
    repeat (3) @(negedge clock);
    reset_readback_mismatch = 1'b0;
    expect_st(ST_SAFE, 5'h01);
    fault_cmd = 1'b1;
    wait_st(ST_SAFE, n);
    fault_cmd = 1'b0;
    check({7'h00, error_pin_fail_flag}, 8'h01);
    check({5'h00, mcu_reset_output, driver_enable_output, main_reg_on}, 8'h05);
    five_volt_reg_enable = rng[3];
    sensor_supply_enable = rng[4];
    repeat (2) @(negedge clock);
    check({6'h00, five_volt_on, sensor_supply_on}, {6'h00, rng[3], rng[4]});
    safe_out(tmo - 2, 4'h1);
    leave_diag(1'b0, 4'h1);
    reset_monitor_disable = 1'b0;
    expect_st(ST_SAFE, 5'h02);
    reset_readback_mismatch = 1'b1;
    wait_st(ST_SAFE, n);
    reset_readback_mismatch = 1'b0;
    check({7'h00, reset_readback_error_flag}, 8'h01);
    reset_readback_error_clear = 1'b1;
    @(negedge clock);
    reset_readback_error_clear = 1'b0;
    safe_out(tmo - 1, 4'h2);
    leave_diag(1'b1, 4'h3);
    repeat (200) @(negedge clock);
    check({5'h00, state}, {5'h00, ST_SAFE});
    expect_st(ST_RESET, 5'h03);
    expect_st(ST_DIAG, 5'h03);
    safe_no_timeout_bit = 1'b0;
    wait_st(ST_DIAG, n);
    expect_st(ST_SAFE, 5'h04);
    cfg_crc_error_flag = 1'b1;
    wait_st(ST_SAFE, n);
    cfg_crc_error_flag = 1'b0;
    safe_out(LONG, 4'h4);
    expect_st(ST_SAFE, 5'h05);
    bist = 3'h1 << (rng[7:6] % 3);
    wait_st(ST_SAFE, n);
    bist = 3'h0;
    safe_out(LONG, 4'h5);
    power_down_threshold_use = 1'b1;
    expect_st(ST_SAFE, 5'h06);
    expect_st(ST_STANDBY, 5'h06);
    wait_st(ST_SAFE, n);
    check(8'(n >= DIAG - 1 && n <= DIAG + 1), 8'h01);
    wait_st(ST_STANDBY, n);
    power_down_threshold_use = 1'b0;
    rng = xs(rng);
    {bus_wake_input, ignition_input} = rng[0] ? 2'h2 : 2'h1;
    expect_st(ST_RESET, 5'h10);
    expect_st(ST_DIAG, 5'h10);
    wait_st(ST_DIAG, n);
    expect_st(ST_RESET, 5'h00);
    expect_st(ST_DIAG, 5'h00);
    dig = 8'h01 << rng[3:1];
    wait_st(ST_RESET, n);
    check(8'(power_on_reset_event), 8'h01);
    dig = 8'h00;
    wait_st(ST_DIAG, n);
    {bus_wake_input, ignition_input} = 2'h0;
    expect_st(ST_STANDBY, 5'h00);
    ana = 4'h1 << rng[5:4];
    @(negedge clock);
    ana = 4'h0;
    wait_st(ST_STANDBY, n);
    repeat (3) @(negedge clock);
    conclude();
  end
endmodule
